// ===== rtl/scsl_bank.sv
// system control word: event flags, control bits, bus error and arbiter steering
// What this block does
// - one 32-bit read/write control word with flags, control and watchdog bits.
// - word sits at fixed offset in supervisor data space, function code 5.
// - bits 27..24 are event flags set by hardware, readable any time.
// - writing one clears a flag, zero leaves it; several at once.
// - total reset (reset with halt) clears all four flags.
// - bit 27 sets while core has unmasked interrupt pending.
// - bit 26 sets on watchdog timeout; bus error every timeout.
// - bit 25 sets on write to read-only chip-select region.
// - bit 25 sets on every violation regardless of fault enable.
// - bit 24 sets when two or more chip selects assert together.
// - bit 20 set makes write-protect violations raise bus error; resets zero.
// - split bit zero: strobes held through locked cycle, waits on read only.
// - split bit one: strobes drop between portions, grant after write.
// - core locked signal blocks bus grants; split bit resets zero.
// - extra-wait bit adds one wait state on external-master cycles in sync mode only.
// - extra-wait clear: zero-wait internal sync, exact programmed chip waits.
// - bit 17 set makes decode conflicts raise bus error.
// - bit 16 set lets pending interrupt drive internal bus clear.
// - watchdog raises bus error and flag on unterminated cycle.
// - sync mode zero: external accesses take three wait states.
module scsl_bank
   import scsl_pkg::*;
(
   input  wire logic                   i_clock,
   input  wire logic                   i_srst,
   input  wire logic                   i_halt,
   input  wire logic                   i_reg_sel,
   input  wire logic [7:0]             i_reg_addr,
   input  wire logic [2:0]             i_function_code,
   input  wire logic                   i_reg_wr,
   input  wire logic                   i_reg_rd,
   input  wire logic [31:0]            i_reg_wdata,
   input  wire logic                   i_irq_pending_signal,
   input  wire logic                   i_write_protect_hit,
   input  wire logic [3:0]             i_chip_select_req,
   input  wire logic                   i_cycle_active,
   input  wire logic                   i_data_acknowledge,
   input  wire logic                   i_locked_cycle_signal,
   input  wire logic                   i_locked_write_phase,
   input  wire logic                   i_bus_request,
   input  wire logic                   i_external_master,
   input  wire logic [1:0]             i_programmed_waits,
   input  wire logic                   i_write_cycle,
   output logic [31:0]                 o_reg_rdata,
   output logic                        o_reg_ack,
   output logic                        o_bus_error,
   output logic                        o_bus_grant,
   output logic                        o_bus_clear,
   output logic                        o_address_strobe_hold,
   output logic [2:0]                  o_wait_states
);
   typedef struct packed {
      logic [31:0] word;
      logic [31:0] rdata;
      logic        ack;
      logic        bus_error;
      logic        grant;
      logic        bclear;
      logic        as_hold;
      logic [2:0]  waits;
      scsl_lock_t  lock;
      logic [3:0]  csr1;
      logic [3:0]  csr2;
      logic [3:0]  csr3;
   } scsl_bank_state_t;

   scsl_bank_state_t state;
   scsl_bank_state_t next_state;
   scsl_ev_if        ev ();

   function automatic logic multi_hot(input logic [3:0] v);
      return (v & (v - 4'h1)) != 4'h0;
   endfunction : multi_hot

   scsl_wdog u_wdog (
      .i_clock (i_clock),
      .i_srst  (i_srst),
      .ev      (ev)
   );

   assign ev.cycle_active = i_cycle_active;
   assign ev.data_acknowledge_seen   = i_data_acknowledge;
   assign ev.enable       = state.word[SCSL_WDEN_BIT];
   assign ev.count_sel    = state.word[SCSL_WDCN_LSB +: 3];

   ////////////////////////////////////////////////////////////////////////////////
   logic        hit;
   logic [31:0] set_ev;
   logic        conflict;
   logic [2:0]  base_waits;
   logic        split;

   always_comb begin
      next_state = state;
      // chip-select requests come from another clock region in a real chip
      next_state.csr1 = i_chip_select_req;
      next_state.csr2 = state.csr1;
      next_state.csr3 = state.csr2;
      split = state.word[SCSL_SPLIT_BIT];
      hit = i_reg_sel && (i_reg_addr == SCSL_REG_OFFSET)
            && (i_function_code == SCSL_FC_SUPER_DATA);
      conflict = multi_hot(state.csr3) && (state.csr3 == state.csr2);
      set_ev = '0;
      set_ev[SCSL_IPA_BIT] = i_irq_pending_signal;
      set_ev[SCSL_HWT_BIT] = ev.wd_timeout;
      set_ev[SCSL_WPV_BIT] = i_write_protect_hit;
      set_ev[SCSL_ADC_BIT] = conflict;
      next_state.ack = hit && (i_reg_wr || i_reg_rd);
      next_state.rdata = state.rdata;
      if (hit && i_reg_rd) begin
         next_state.rdata = state.word & (SCSL_CTRL_MASK | SCSL_FLAG_MASK);
      end
      if (hit && i_reg_wr) begin
         next_state.word = (state.word & SCSL_FLAG_MASK & ~i_reg_wdata)
                           | (i_reg_wdata & SCSL_CTRL_MASK);
      end
      // a hardware set in the same cycle as a clear wins
      next_state.word = next_state.word | set_ev;
      next_state.bus_error = ev.wd_timeout
         || (i_write_protect_hit && state.word[SCSL_WRITE_PROTECT_FAULT_ENABLE_BIT])
         || (conflict && state.word[SCSL_DECODE_CONFLICT_FAULT_ENABLE_BIT]);
      next_state.bclear = state.word[SCSL_BUS_CLEAR_IRQ_MASK_BIT] && i_irq_pending_signal;
      case (state.lock)
         SCSL_LK_IDLE: begin
            if (i_locked_cycle_signal) begin
               next_state.lock = SCSL_LK_READ;
            end
         end
         SCSL_LK_READ: begin
            if (!i_locked_cycle_signal) begin
               next_state.lock = SCSL_LK_IDLE;
            end else if (i_locked_write_phase) begin
               next_state.lock = SCSL_LK_WRITE;
            end
         end
         SCSL_LK_WRITE: begin
            if (!i_locked_cycle_signal) begin
               next_state.lock = SCSL_LK_IDLE;
            end
         end
         default: begin
            next_state.lock = SCSL_LK_IDLE;
         end
      endcase
      // strobes held through the whole locked cycle unless split is on
      next_state.as_hold = (next_state.lock != SCSL_LK_IDLE) && !split;
      // the locked signal holds off grants until the write ends
      next_state.grant = i_bus_request && !i_locked_cycle_signal
                         && !next_state.bclear;
      if (split) begin
         next_state.grant = next_state.grant && (state.lock == SCSL_LK_IDLE);
      end
      if (i_external_master && !state.word[SCSL_SAM_BIT]) begin
         base_waits = {1'b0, SCSL_ASYNC_WAITS};
      end else if (i_external_master && !i_reg_sel) begin
         base_waits = {1'b0, i_programmed_waits};
      end else if (i_external_master) begin
         base_waits = 3'h0;
      end else begin
         base_waits = {1'b0, i_programmed_waits};
      end
      // locked write portion gets waits only when split is on
      if (i_locked_cycle_signal && i_write_cycle && !split) begin
         base_waits = 3'h0;
      end
      next_state.waits = base_waits + {2'h0, i_external_master && state.word[SCSL_SAM_BIT]
                         && state.word[SCSL_EXTERNAL_MASTER_EXTRA_WAIT_BIT]};
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state <= '0;
         // plain reset keeps flags; only reset with halt clears them
         state.word <= SCSL_RESET_VALUE;
         if (!i_halt) begin
            state.word[SCSL_IPA_BIT:SCSL_ADC_BIT] <= next_state.word[SCSL_IPA_BIT:SCSL_ADC_BIT];
         end
      end else begin
         state <= next_state;
      end
   end

   assign o_reg_rdata           = state.rdata;
   assign o_reg_ack             = state.ack;
   assign o_bus_error           = state.bus_error;
   assign o_bus_grant           = state.grant;
   assign o_bus_clear           = state.bclear;
   assign o_address_strobe_hold = state.as_hold;
   assign o_wait_states         = state.waits;

   ////////////////////////////////////////////////////////////////////////////////
   // event flags and bus error
   chk_flag_set_wins: assert property (@(posedge i_clock) disable iff (i_srst)
      i_irq_pending_signal |=> state.word[SCSL_IPA_BIT])
      else $error("irq flag not set");

   chk_wd_bus_error: assert property (@(posedge i_clock) disable iff (i_srst)
      ev.wd_timeout |=> o_bus_error && state.word[SCSL_HWT_BIT])
      else $error("timeout without bus error");

   chk_wpv_bus_error: assert property (@(posedge i_clock) disable iff (i_srst)
      i_write_protect_hit |=> o_bus_error == $past(state.word[SCSL_WRITE_PROTECT_FAULT_ENABLE_BIT]) || $past(ev.wd_timeout)
         || $past(conflict))
      else $error("write protect bus error wrong");

   chk_wpv_flag: assert property (@(posedge i_clock) disable iff (i_srst)
      i_write_protect_hit |=> state.word[SCSL_WPV_BIT])
      else $error("write protect flag missing");

   chk_bus_error_quiet: assert property (@(posedge i_clock) disable iff (i_srst)
      !ev.wd_timeout && !conflict && !(i_write_protect_hit && state.word[SCSL_WRITE_PROTECT_FAULT_ENABLE_BIT])
      |=> !o_bus_error)
      else $error("bus error without cause");

   chk_adc_flag: assert property (@(posedge i_clock) disable iff (i_srst)
      conflict |=> state.word[SCSL_ADC_BIT])
      else $error("conflict flag missing");

   chk_adc_bus_error: assert property (@(posedge i_clock) disable iff (i_srst)
      conflict && state.word[SCSL_DECODE_CONFLICT_FAULT_ENABLE_BIT] |=> o_bus_error)
      else $error("conflict bus error missing");

   chk_w1c_clear: assert property (@(posedge i_clock) disable iff (i_srst)
      hit && i_reg_wr && i_reg_wdata[SCSL_ADC_BIT] && !conflict |=> !state.word[SCSL_ADC_BIT])
      else $error("flag not cleared");

   chk_ipa_clear: assert property (@(posedge i_clock) disable iff (i_srst)
      hit && i_reg_wr && i_reg_wdata[SCSL_IPA_BIT] && !i_irq_pending_signal
      |=> !state.word[SCSL_IPA_BIT])
      else $error("irq flag not cleared");

   chk_flag_keep: assert property (@(posedge i_clock) disable iff (i_srst)
      hit && i_reg_wr && !i_reg_wdata[SCSL_IPA_BIT] && state.word[SCSL_IPA_BIT]
      |=> state.word[SCSL_IPA_BIT])
      else $error("flag lost on zero write");

   // register access
   chk_reserved_zero: assert property (@(posedge i_clock) disable iff (i_srst)
      o_reg_rdata[31:28] == 4'h0)
      else $error("reserved bits nonzero");

   chk_reserved_held: assert property (@(posedge i_clock) disable iff (i_srst)
      state.word[31:28] == 4'h0)
      else $error("reserved bits stored");

   chk_ack_hit: assert property (@(posedge i_clock) disable iff (i_srst)
      hit && (i_reg_wr || i_reg_rd) |=> o_reg_ack)
      else $error("access not acknowledged");

   chk_ack_miss: assert property (@(posedge i_clock) disable iff (i_srst)
      !hit |=> !o_reg_ack)
      else $error("refused access acknowledged");

   chk_rdata_word: assert property (@(posedge i_clock) disable iff (i_srst)
      hit && i_reg_rd |=> o_reg_rdata == ($past(state.word) & (SCSL_CTRL_MASK | SCSL_FLAG_MASK)))
      else $error("read data wrong");

   chk_ctrl_write: assert property (@(posedge i_clock) disable iff (i_srst)
      hit && i_reg_wr |=> state.word[23:8] == $past(i_reg_wdata[23:8]))
      else $error("control bits not written");

   // arbiter steering and strobes
   chk_lock_no_grant: assert property (@(posedge i_clock) disable iff (i_srst)
      i_locked_cycle_signal |=> !o_bus_grant)
      else $error("grant during locked cycle");

   chk_split_grant: assert property (@(posedge i_clock) disable iff (i_srst)
      state.word[SCSL_SPLIT_BIT] && state.lock != SCSL_LK_IDLE |=> !o_bus_grant)
      else $error("grant before locked write ends");

   chk_split_hold: assert property (@(posedge i_clock) disable iff (i_srst)
      state.word[SCSL_SPLIT_BIT] |=> !o_address_strobe_hold)
      else $error("strobe held with split on");

   chk_hold_locked: assert property (@(posedge i_clock) disable iff (i_srst)
      !state.word[SCSL_SPLIT_BIT] && i_locked_cycle_signal |=> o_address_strobe_hold)
      else $error("strobe not held in locked cycle");

   chk_bclear_mask: assert property (@(posedge i_clock) disable iff (i_srst)
      !state.word[SCSL_BUS_CLEAR_IRQ_MASK_BIT] && !$past(state.word[SCSL_BUS_CLEAR_IRQ_MASK_BIT]) |-> !o_bus_clear)
      else $error("bus clear while masked");

   chk_bclear_on: assert property (@(posedge i_clock) disable iff (i_srst)
      state.word[SCSL_BUS_CLEAR_IRQ_MASK_BIT] && i_irq_pending_signal |=> o_bus_clear)
      else $error("bus clear missing");

   // wait states
   chk_async_waits: assert property (@(posedge i_clock) disable iff (i_srst)
      i_external_master && !state.word[SCSL_SAM_BIT] && !(i_locked_cycle_signal && i_write_cycle)
      |=> o_wait_states == 3'h3)
      else $error("async wait count wrong");

   chk_external_master_extra_wait_wait: assert property (@(posedge i_clock) disable iff (i_srst)
      i_external_master && state.word[SCSL_SAM_BIT] && state.word[SCSL_EXTERNAL_MASTER_EXTRA_WAIT_BIT]
      |=> o_wait_states != 3'h0)
      else $error("extra wait state missing");

   chk_sync_int_wait: assert property (@(posedge i_clock) disable iff (i_srst)
      i_external_master && state.word[SCSL_SAM_BIT] && !state.word[SCSL_EXTERNAL_MASTER_EXTRA_WAIT_BIT] && i_reg_sel
      |=> o_wait_states == 3'h0)
      else $error("sync internal access waited");

   chk_cs_wait: assert property (@(posedge i_clock) disable iff (i_srst)
      i_external_master && state.word[SCSL_SAM_BIT] && !state.word[SCSL_EXTERNAL_MASTER_EXTRA_WAIT_BIT] && !i_reg_sel
      && !(i_locked_cycle_signal && i_write_cycle)
      |=> o_wait_states == {1'b0, $past(i_programmed_waits)})
      else $error("chip select wait count wrong");
endmodule : scsl_bank

// ===== rtl/scsl_pkg.sv
// package: register map, field positions, reset values and timing counts
package scsl_pkg;
   localparam logic [7:0]  SCSL_REG_OFFSET   = 8'hf4;
   localparam logic [2:0]  SCSL_FC_SUPER_DATA = 3'h5;
   localparam int          SCSL_IPA_BIT      = 27;
   localparam int          SCSL_HWT_BIT      = 26;
   localparam int          SCSL_WPV_BIT      = 25;
   localparam int          SCSL_ADC_BIT      = 24;
   localparam int          SCSL_WRITE_PROTECT_FAULT_ENABLE_BIT     = 20;
   localparam int          SCSL_SPLIT_BIT    = 19;
   localparam int          SCSL_EXTERNAL_MASTER_EXTRA_WAIT_BIT     = 18;
   localparam int          SCSL_DECODE_CONFLICT_FAULT_ENABLE_BIT     = 17;
   localparam int          SCSL_BUS_CLEAR_IRQ_MASK_BIT     = 16;
   localparam int          SCSL_SAM_BIT      = 12;
   localparam int          SCSL_WDEN_BIT     = 11;
   localparam int          SCSL_WDCN_LSB     = 8;
   // writable control bits 23..8; reserved 31..28 read zero
   localparam logic [31:0] SCSL_CTRL_MASK    = 32'h00ffff00;
   localparam logic [31:0] SCSL_FLAG_MASK    = 32'h0f000000;
   localparam logic [31:0] SCSL_RESET_VALUE  = 32'h00000800;
   localparam logic [1:0]  SCSL_ASYNC_WAITS  = 2'h3;
   localparam int          SCSL_WD_BASE_LOG2 = 7;
   localparam int          SCSL_WD_CNT_W     = 15;

   typedef enum logic [1:0] {SCSL_LK_IDLE, SCSL_LK_READ, SCSL_LK_WRITE} scsl_lock_t;
endpackage : scsl_pkg

// ===== rtl/scsl_ev_if.sv
// interface: event pulses and bus-error requests between watchdog and register bank
interface scsl_ev_if;
   logic wd_timeout;
   logic cycle_active;
   logic data_acknowledge_seen;
   logic enable;
   logic [2:0] count_sel;
   modport wdog (input cycle_active, input data_acknowledge_seen, input enable, input count_sel,
                 output wd_timeout);
   modport bank (output cycle_active, output data_acknowledge_seen, output enable, output count_sel,
                 input wd_timeout);
endinterface : scsl_ev_if

// ===== rtl/scsl_wdog.sv
// bus watchdog: times an unterminated bus cycle
module scsl_wdog
   import scsl_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_srst,
   scsl_ev_if.wdog   ev
);
   typedef struct packed {
      logic [SCSL_WD_CNT_W-1:0] count;
      logic                     timeout;
   } scsl_wd_state_t;

   scsl_wd_state_t state;
   scsl_wd_state_t next_state;
   logic [SCSL_WD_CNT_W-1:0] limit;

   always_comb begin
      limit = SCSL_WD_CNT_W'((32'h1 << (SCSL_WD_BASE_LOG2 + int'(ev.count_sel))) - 32'h1);
      next_state = state;
      next_state.timeout = 1'b0;
      if (!ev.cycle_active || ev.data_acknowledge_seen || !ev.enable) begin
         next_state.count = '0;
      end else if (state.count == limit) begin
         // restart so a stuck cycle keeps raising bus errors
         next_state.timeout = 1'b1;
         next_state.count = '0;
      end else begin
         next_state.count = state.count + 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign ev.wd_timeout = state.timeout;

   chk_wd_no_early: assert property (@(posedge i_clock) disable iff (i_srst)
      $rose(ev.cycle_active) && ev.enable |-> !ev.wd_timeout[*8])
      else $error("watchdog fired too early");
endmodule : scsl_wdog

// ===== verification/scsl_partner.sv
// partner model: bus cycle source that ends promptly on acknowledge or stalls
module scsl_partner (
   input  wire logic i_clock,
   input  wire logic i_go,
   input  wire logic i_slow,
   output logic      o_cycle_active,
   output logic      o_data_acknowledge
);
   timeunit 1ns;
   timeprecision 1ps;
   int age = 0;
   always @(posedge i_clock) begin
      age <= i_go ? age + 1 : 0;
   end
   // a stalled cycle never acknowledges, so it stays active until i_go drops
   assign o_cycle_active = i_go && (i_slow || age < 3);
   assign o_data_acknowledge        = i_go && !i_slow && age == 2;
endmodule : scsl_partner

// ===== verification/scsl_tb.sv
// testbench: register access, event flags, watchdog, arbiter steering and wait states
module scsl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import scsl_pkg::*;
   logic        i_clock = 0, i_srst = 1, i_halt = 1, sel = 0, wr = 0, rd = 0;
   logic [7:0]  addr = 0;
   logic [2:0]  fc = 0, wst;
   logic [31:0] wdata = 0, rdata, mdl;
   logic        irq = 0, wph = 0, lock = 0, breq = 0, extm = 0, go = 0, slow = 0;
   logic [3:0]  csr = 0;
   logic        cact, dtk, ack, bus_error, bgnt, bclr;
   int          n_mismatch = 0, n_tests = 0, nb = 0, nb0, k, n;
   always #12.5 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      if (bus_error === 1'h1) nb <= nb + 1;
   end
   scsl_bank u_scsl_bank (.i_clock(i_clock), .i_srst(i_srst), .i_halt(i_halt),
      .i_reg_sel(sel), .i_reg_addr(addr), .i_function_code(fc), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_wdata(wdata), .i_irq_pending_signal(irq),
      .i_write_protect_hit(wph), .i_chip_select_req(csr), .i_cycle_active(cact),
      .i_data_acknowledge(dtk), .i_locked_cycle_signal(lock), .i_locked_write_phase(1'h0),
      .i_bus_request(breq), .i_external_master(extm), .i_programmed_waits(2'h1),
      .i_write_cycle(1'h0), .o_reg_rdata(rdata), .o_reg_ack(ack), .o_bus_error(bus_error),
      .o_bus_grant(bgnt), .o_bus_clear(bclr), .o_address_strobe_hold(), .o_wait_states(wst));
   scsl_partner u_scsl_partner (.i_clock(i_clock), .i_go(go), .i_slow(slow),
      .o_cycle_active(cact), .o_data_acknowledge(dtk));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic tick(int c);
      repeat (c) @(posedge i_clock);
      #2;
   endtask : tick
   // one access cycle, then an idle cycle so strobes never toggle twice in a step
   task automatic acc(logic w, logic [7:0] a, logic [2:0] f, logic [31:0] d, logic ok);
      sel = 1'h1;
      wr = w;
      rd = !w;
      addr = a;
      fc = f;
      wdata = d;
      tick(1);
      chk("ack", {31'h0, ok}, {31'h0, ack});
      sel = 1'h0;
      wr = 1'h0;
      rd = 1'h0;
      tick(1);
   endtask : acc
   task automatic wreg(logic [31:0] d);
      acc(1'h1, SCSL_REG_OFFSET, SCSL_FC_SUPER_DATA, d, 1'h1);
      mdl = (d & SCSL_CTRL_MASK) | (mdl & SCSL_FLAG_MASK & ~d);
   endtask : wreg
   task automatic rreg(string nm);
      acc(1'h0, SCSL_REG_OFFSET, SCSL_FC_SUPER_DATA, 32'h0, 1'h1);
      chk(nm, mdl, rdata);
   endtask : rreg
   task automatic wait_bus_error();
      n = 0;
      while (bus_error !== 1'h1 && n < 300) begin
         tick(1);
         n++;
      end
      if (n == 300) begin
         n_mismatch++;
         give_verdict();
      end
   endtask : wait_bus_error
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      k = $urandom(32'hd283);
      mdl = SCSL_RESET_VALUE;
      tick(12);
      i_srst = 1'h0;
      i_halt = 1'h0;
      rreg("reset word");
      acc(1'h1, SCSL_REG_OFFSET, 3'h6, 32'h00ffff00, 1'h0);
      acc(1'h1, 8'hf0, SCSL_FC_SUPER_DATA, 32'h00ffff00, 1'h0);
      rreg("after refused");
      for (k = 0; k < 6; k++) begin
         wreg($urandom);
         rreg("random word");
      end
      // both fault enables off, then on; flags set either way
      for (k = 0; k < 2; k++) begin
         wreg(32'h0f000800 | (k ? 32'h00120000 : 32'h0));
         nb0 = nb;
         irq = 1'h1;
         wph = 1'h1;
         tick(1);
         irq = 1'h0;
         wph = 1'h0;
         tick(2);
         chk("wp bus error", nb0 + k, nb);
         // held two cycles so the last two synchroniser stages agree
         csr = 4'h5;
         tick(2);
         csr = 4'h0;
         tick(6);
         chk("conflict bus error", nb0 + 2 * k, nb);
         mdl |= 32'h0b000000;
         rreg("event flags");
         wreg(32'h08000800 | (k ? 32'h00120000 : 32'h0));
         rreg("single clear");
      end
      wreg(32'h0f000800);
      rreg("multi clear");
      nb0 = nb;
      go = 1'h1;
      tick(20);
      go = 1'h0;
      chk("prompt cycle", nb0, nb);
      tick(1);
      slow = 1'h1;
      go = 1'h1;
      wait_bus_error();
      chk("timeout near 128", 32'h1, {31'h0, n > 124 && n < 132});
      tick(1);
      wait_bus_error();
      chk("repeat timeout", 32'h1, {31'h0, n > 124 && n < 132});
      go = 1'h0;
      slow = 1'h0;
      mdl |= 32'h04000000;
      rreg("timeout flag");
      wreg(32'h0f010800);
      irq = 1'h1;
      tick(3);
      chk("bus clear on", 32'h1, {31'h0, bclr});
      irq = 1'h0;
      wreg(32'h08010800);
      chk("bus clear off", 32'h0, {31'h0, bclr});
      wreg(32'h00000800);
      irq = 1'h1;
      tick(3);
      chk("bus clear masked", 32'h0, {31'h0, bclr});
      irq = 1'h0;
      wreg(32'h0f000800);
      breq = 1'h1;
      lock = 1'h1;
      tick(4);
      chk("grant in lock", 32'h0, {31'h0, bgnt});
      lock = 1'h0;
      tick(4);
      chk("grant after lock", 32'h1, {31'h0, bgnt});
      breq = 1'h0;
      extm = 1'h1;
      for (k = 0; k < 3; k++) begin
         wreg(k == 0 ? 32'h00000800 : (k == 1 ? 32'h00001800 : 32'h00041800));
         tick(2);
         chk("wait states", k == 0 ? 32'h3 : k, {29'h0, wst});
      end
      extm = 1'h0;
      // reset alone keeps the flags, reset with halt clears them
      for (k = 0; k < 2; k++) begin
         wph = 1'h1;
         tick(1);
         wph = 1'h0;
         tick(2);
         mdl |= 32'h02000000;
         i_halt = k;
         i_srst = 1'h1;
         tick(2);
         i_srst = 1'h0;
         i_halt = 1'h0;
         mdl = SCSL_RESET_VALUE | (k ? 32'h0 : mdl & SCSL_FLAG_MASK);
         rreg("after reset");
      end
      give_verdict();
   end
endmodule : scsl_tb
